//--- rtcc_regs.svh
// register offsets, field positions, reset values and tick counts of the clock trim block
`ifndef RTCC_REGS_SVH
`define RTCC_REGS_SVH
`define RTCC_TRIM_ADDR 8'h07
`define RTCC_TRIM_RESET 8'h80
`define RTCC_OUT_BIT 7
`define RTCC_FREQ_CHECK_BIT 6
`define RTCC_DIR_BIT 5
`define RTCC_MAG_MSB 4
`define RTCC_MAG_LSB 0
`define RTCC_TICKS_NOM 10'h200
`define RTCC_TICKS_SHORT 10'h1FF
`define RTCC_TICKS_LONG 10'h201
`define RTCC_SECS_PER_MIN 6'h3C
`define RTCC_MINS_FAST 4'h8
`define RTCC_MINS_SLOW 4'h0
`define RTCC_XTAL_DIV 64
`define RTCC_PRE_W 6
`endif

//--- rtcc_pkg.sv
// types shared by the clock trim block
package rtcc_pkg;
   typedef struct packed {
      logic [5:0] cnt;
      logic tick;
      logic sq;
   } rtcc_pre_s;

   typedef struct packed {
      logic [9:0] tick_cnt;
      logic [5:0] sec_cnt;
      logic [3:0] min_cnt;
      logic [7:0] trim;
      logic [4:0] mag;
      logic speed_up;
      logic [7:0] rdata;
      logic pin_oe;
      logic sec_pulse;
   } rtcc_state_s;
endpackage

//--- rtcc_prescale.sv
// crystal pulse divider producing the 512 Hz tick and the steady test square wave
`timescale 1ns/1ns
`include "rtcc_regs.svh"
module rtcc_prescale
   import rtcc_pkg::*;
#(
   parameter int TICK_DIV = `RTCC_XTAL_DIV
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_xtal_pulse,
   output logic o_tick,
   output logic o_square
);
   localparam logic [5:0] LAST = 6'(TICK_DIV - 1);
   localparam logic [5:0] HALF = 6'(TICK_DIV / 2);

   rtcc_pre_s st_r;
   rtcc_pre_s st_nxt;

   // refused at elaboration: an odd or oversized divide cannot give an even square wave
   if (TICK_DIV < 2 || TICK_DIV > (1 << `RTCC_PRE_W) || (TICK_DIV % 2) != 0) begin : g_div_check
      $error("TICK_DIV must be even and fit the prescale counter");
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.tick = 1'b0;
      if (i_xtal_pulse) begin
         st_nxt.cnt = (st_r.cnt == LAST) ? 6'h00 : st_r.cnt + 6'h01;
         st_nxt.tick = (st_r.cnt == LAST);
      end
      // taken before any trim so the test wave never shows short or long seconds
      st_nxt.sq = (st_nxt.cnt >= HALF);
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_tick = st_r.tick;
   assign o_square = st_r.sq;

   chk_tick_div: assert property (
      @(posedge i_clock) disable iff (i_rst)
      (i_xtal_pulse && st_r.cnt == LAST) |=> (o_tick && st_r.cnt == 6'h00))
      else $error("tick not produced at end of crystal divide");

   chk_square_steady: assert property (
      @(posedge i_clock) disable iff (i_rst)
      $changed(o_square) |-> $past(i_xtal_pulse))
      else $error("test square wave moved without a crystal pulse");
endmodule

//--- rtcc_calib.sv
// periodic counter correction of the seconds chain with trim register and shared pin
// Summary of operation
// - nominal second is 512 ticks; long second 513, short second 511
// - magnitude in bits 4..0, direction in bit 5 of trim clock_trim_control
// - speed-up applied once per 8 minutes, slow-down once per 16 minutes
// - speed-up with magnitude N shortens exactly N seconds of one minute
// - seven nominal minutes follow a speed-up corrected minute
// - slow-down with magnitude N lengthens N seconds, then 15 nominal minutes
// - magnitude spans 1 to 31; zero leaves every second nominal
// - frequency test output taken ahead of correction, always steady
// - test bit set, interrupt enable clear and not on backup drives 512 Hz on shared pin
`timescale 1ns/1ns
`include "rtcc_regs.svh"
module rtcc_calib
   import rtcc_pkg::*;
#(
   parameter int TICK_DIV = `RTCC_XTAL_DIV
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_xtal_pulse,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_osc_fail_irq_enable,
   input wire logic i_osc_fail,
   input wire logic i_on_backup,
   input wire logic i_pin_in,
   output logic [7:0] o_reg_rdata,
   output logic o_second_pulse,
   output logic o_freq_check_output,
   output logic o_pin_out,
   output logic o_pin_oe
);
   rtcc_state_s st_r;
   rtcc_state_s st_nxt;
   logic tick;
   logic square;
   logic corr_sec;
   logic [9:0] sec_len;
   logic sec_end;
   logic min_end;
   logic period_end;
   logic pin_level;

   // ticks in the current second, given the latched trim
   function automatic logic [9:0] second_length(input logic corr, input logic up);
      if (!corr) begin
         second_length = `RTCC_TICKS_NOM;
      end else if (up) begin
         second_length = `RTCC_TICKS_SHORT;
      end else begin
         second_length = `RTCC_TICKS_LONG;
      end
   endfunction

   rtcc_prescale #(
      .TICK_DIV(TICK_DIV)
   ) u_prescale (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_xtal_pulse(i_xtal_pulse),
      .o_tick(tick),
      .o_square(square)
   );

   always_comb begin
      st_nxt = st_r;
      st_nxt.sec_pulse = 1'b0;
      // minute 0 of each period is the corrected one; mag of zero matches no second
      corr_sec = (st_r.min_cnt == 4'h0) && ({1'b0, st_r.mag} > st_r.sec_cnt);
      sec_len = second_length(corr_sec, st_r.speed_up);
      sec_end = tick && (st_r.tick_cnt == sec_len - 10'h001);
      min_end = sec_end && (st_r.sec_cnt == `RTCC_SECS_PER_MIN - 6'h01);
      // slow period ends when the 4-bit counter reaches 15, which then reloads RTCC_MINS_SLOW
      period_end = min_end && (st_r.speed_up ?
         (st_r.min_cnt == `RTCC_MINS_FAST - 4'h1) : (st_r.min_cnt == 4'hF));

      if (tick) begin
         st_nxt.tick_cnt = sec_end ? 10'h000 : st_r.tick_cnt + 10'h001;
      end
      if (sec_end) begin
         st_nxt.sec_pulse = 1'b1;
         st_nxt.sec_cnt = min_end ? 6'h00 : st_r.sec_cnt + 6'h01;
      end
      if (min_end) begin
         st_nxt.min_cnt = period_end ? `RTCC_MINS_SLOW : st_r.min_cnt + 4'h1;
      end
      // new trim only takes hold at a period boundary so a period is never split
      if (period_end) begin
         st_nxt.mag = st_r.trim[`RTCC_MAG_MSB:`RTCC_MAG_LSB];
         st_nxt.speed_up = st_r.trim[`RTCC_DIR_BIT];
      end

      if (i_reg_wr && i_reg_addr == `RTCC_TRIM_ADDR) begin
         st_nxt.trim = i_reg_wdata;
      end
      if (i_reg_rd) begin
         st_nxt.rdata = (i_reg_addr == `RTCC_TRIM_ADDR) ? st_r.trim : 8'h00;
      end

      // shared pin priority: backup forces the output bit, then interrupt, then test
      if (i_on_backup) begin
         pin_level = st_r.trim[`RTCC_OUT_BIT];
      end else if (i_osc_fail_irq_enable) begin
         pin_level = ~i_osc_fail;
      end else if (st_r.trim[`RTCC_FREQ_CHECK_BIT]) begin
         pin_level = square;
      end else begin
         pin_level = st_r.trim[`RTCC_OUT_BIT];
      end
      st_nxt.pin_oe = ~pin_level;
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         st_r <= '0;
         st_r.trim <= `RTCC_TRIM_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_reg_rdata = st_r.rdata;
   assign o_second_pulse = st_r.sec_pulse;
   assign o_freq_check_output = square;
   // open-drain pad: data is always low, only the enable moves; read-back is not needed here
   assign o_pin_out = 1'b0;
   assign o_pin_oe = st_r.pin_oe;

   chk_short_second: assert property (
      @(posedge i_clock) disable iff (i_rst)
      (tick && st_r.tick_cnt == 10'h1FE && st_r.min_cnt == 4'h0 && st_r.speed_up
         && {1'b0, st_r.mag} > st_r.sec_cnt) |=> (st_r.tick_cnt == 10'h000 && o_second_pulse))
      else $error("short second did not end at 511 ticks");

   chk_long_second: assert property (
      @(posedge i_clock) disable iff (i_rst)
      (tick && st_r.tick_cnt == 10'h1FF && st_r.min_cnt == 4'h0 && !st_r.speed_up
         && {1'b0, st_r.mag} > st_r.sec_cnt) |=> (st_r.tick_cnt == 10'h200 && !o_second_pulse))
      else $error("long second ended before 513 ticks");

   chk_nominal_second: assert property (
      @(posedge i_clock) disable iff (i_rst)
      (tick && st_r.tick_cnt == 10'h1FF && (st_r.min_cnt != 4'h0
         || {1'b0, st_r.mag} <= st_r.sec_cnt)) |=> (st_r.tick_cnt == 10'h000 && o_second_pulse))
      else $error("uncorrected second was not 512 ticks");

   chk_zero_mag: assert property (
      @(posedge i_clock) disable iff (i_rst)
      (st_r.mag == 5'h00) |-> (st_r.tick_cnt <= 10'h1FF))
      else $error("zero magnitude produced a long second");

   chk_fast_period: assert property (
      @(posedge i_clock) disable iff (i_rst)
      (st_r.speed_up && $stable(st_r.speed_up)) |-> (st_r.min_cnt <= 4'h7))
      else $error("speed-up period exceeded eight minutes");

   chk_trim_write: assert property (
      @(posedge i_clock) disable iff (i_rst)
      (i_reg_wr && i_reg_addr == `RTCC_TRIM_ADDR) |=> (st_r.trim == $past(i_reg_wdata)))
      else $error("trim register write not stored");

   chk_trim_sample: assert property (
      @(posedge i_clock) disable iff (i_rst)
      ($changed(st_r.mag) || $changed(st_r.speed_up)) |->
         (st_r.min_cnt == 4'h0 && st_r.sec_cnt == 6'h00 && st_r.tick_cnt == 10'h000))
      else $error("trim taken outside a period boundary");

   chk_pin_test: assert property (
      @(posedge i_clock) disable iff (i_rst)
      (!i_on_backup && !i_osc_fail_irq_enable && st_r.trim[`RTCC_FREQ_CHECK_BIT])
         |=> (o_pin_oe == ~$past(square)))
      else $error("shared pin did not follow test square wave");

   chk_pulse_single: assert property (
      @(posedge i_clock) disable iff (i_rst)
      o_second_pulse |=> !o_second_pulse)
      else $error("second pulse lasted more than one cycle");

   chk_tick_bound: assert property (
      @(posedge i_clock) disable iff (i_rst)
      st_r.tick_cnt <= `RTCC_TICKS_LONG - 10'h001)
      else $error("tick count ran past the longest second");

   chk_zero_no_short: assert property (
      @(posedge i_clock) disable iff (i_rst)
      (tick && st_r.tick_cnt == 10'h1FE && st_r.mag == 5'h00) |=> (st_r.tick_cnt == 10'h1FF))
      else $error("zero magnitude produced a short second");

   chk_read_trim: assert property (
      @(posedge i_clock) disable iff (i_rst)
      (i_reg_rd && i_reg_addr == `RTCC_TRIM_ADDR) |=> (o_reg_rdata == $past(st_r.trim)))
      else $error("trim register read returned wrong data");

   chk_read_other: assert property (
      @(posedge i_clock) disable iff (i_rst)
      (i_reg_rd && i_reg_addr != `RTCC_TRIM_ADDR) |=> (o_reg_rdata == 8'h00))
      else $error("unmapped register read was not zero");

   chk_rdata_hold: assert property (
      @(posedge i_clock) disable iff (i_rst)
      !i_reg_rd |=> $stable(o_reg_rdata))
      else $error("read data changed without a read");

   chk_pin_irq: assert property (
      @(posedge i_clock) disable iff (i_rst)
      (!i_on_backup && i_osc_fail_irq_enable) |=> (o_pin_oe == $past(i_osc_fail)))
      else $error("interrupt did not take the shared pin");

   chk_pin_backup: assert property (
      @(posedge i_clock) disable iff (i_rst)
      i_on_backup |=> (o_pin_oe == !$past(st_r.trim[`RTCC_OUT_BIT])))
      else $error("backup supply did not leave the output bit on the pin");
endmodule

//--- rtcc_calib_bench.sv
// self-checking bench for the clock trim block
`timescale 1ns/1ns
`include "rtcc_regs.svh"
module rtcc_calib_bench;
   import rtcc_pkg::*;
   localparam int DIV = 2;
   // one second is 512 ticks of DIV crystal pulses, a pulse every two clocks
   localparam logic [31:0] SEC = 32'h800;
   logic i_clock = 1'b0;
   logic i_rst = 1'b1;
   logic i_xtal_pulse = 1'b0;
   logic i_reg_wr = 1'b0;
   logic i_reg_rd = 1'b0;
   logic [7:0] i_reg_addr = 8'h00;
   logic [7:0] i_reg_wdata = 8'h00;
   logic i_osc_fail_irq_enable = 1'b0;
   logic i_osc_fail = 1'b0;
   logic i_on_backup = 1'b0;
   logic [7:0] o_reg_rdata;
   logic o_second_pulse;
   logic o_freq_check_output;
   logic o_pin_out;
   logic o_pin_oe;
   logic [31:0] n;
   logic [31:0] m;
   logic [31:0] q;
   int err_count = 0;
   int checks = 0;

   // open-drain pin with pull-up: low only while the block drives it
   rtcc_calib #(.TICK_DIV(DIV)) dut (
      .i_clock(i_clock), .i_rst(i_rst), .i_xtal_pulse(i_xtal_pulse),
      .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
      .i_reg_wdata(i_reg_wdata), .i_osc_fail_irq_enable(i_osc_fail_irq_enable),
      .i_osc_fail(i_osc_fail), .i_on_backup(i_on_backup), .i_pin_in(~o_pin_oe),
      .o_reg_rdata(o_reg_rdata), .o_second_pulse(o_second_pulse),
      .o_freq_check_output(o_freq_check_output), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe));

   always #5 i_clock = ~i_clock;
   always @(posedge i_clock) #1 i_xtal_pulse = ~i_xtal_pulse;

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic summarize;
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // one register access; read data is settled just after the read edge
   task automatic bus(input logic wr, input logic [7:0] addr, input logic [7:0] data);
      @(posedge i_clock);
      #1;
      i_reg_wr = wr;
      i_reg_rd = ~wr;
      i_reg_addr = addr;
      i_reg_wdata = data;
      @(posedge i_clock);
      #1;
      i_reg_wr = 1'b0;
      i_reg_rd = 1'b0;
   endtask

   task automatic pin_case(input logic bak, input logic irq, input logic osc, input logic exp);
      @(posedge i_clock);
      #1;
      i_on_backup = bak;
      i_osc_fail_irq_enable = irq;
      i_osc_fail = osc;
      repeat (3) @(posedge i_clock);
      #1;
      cmp({31'h0, o_pin_oe}, {31'h0, exp});
   endtask

   // rising edges of the test output and of the pin drive over one nominal second
   // also counts cycles where the pin drive is not the inverse of the previous test level
   task automatic count_rises(output logic [31:0] fr, output logic [31:0] pr,
      output logic [31:0] bad);
      logic f;
      logic p;
      fr = 32'h0;
      pr = 32'h0;
      bad = 32'h0;
      f = o_freq_check_output;
      p = o_pin_oe;
      repeat (SEC) begin
         @(posedge i_clock);
         #1;
         if (o_freq_check_output === 1'b1 && f === 1'b0) fr++;
         if (o_pin_oe === 1'b1 && p === 1'b0) pr++;
         if (o_pin_oe !== ~f) bad++;
         f = o_freq_check_output;
         p = o_pin_oe;
      end
   endtask

   // cycles from one second pulse to the next, bounded against a stuck chain
   task automatic sec_len(output logic [31:0] len);
      len = 32'h0;
      while (o_second_pulse !== 1'b1 && len < 32'h2000) begin
         @(posedge i_clock);
         #1;
         len++;
      end
      len = 32'h0;
      do begin
         @(posedge i_clock);
         #1;
         len++;
      end while (o_second_pulse !== 1'b1 && len < 32'h2000);
   endtask

   task automatic t_reset;
      repeat (16) @(posedge i_clock);
      #1;
      cmp({24'h0, o_reg_rdata}, 32'h0);
      cmp({31'h0, o_pin_oe}, 32'h0);
      cmp({31'h0, o_second_pulse}, 32'h0);
      cmp({31'h0, o_freq_check_output}, 32'h0);
      cmp({31'h0, o_pin_out}, 32'h0);
      i_rst = 1'b0;
   endtask

   task automatic t_regs;
      bus(1'b0, `RTCC_TRIM_ADDR, 8'h00);
      cmp({24'h0, o_reg_rdata}, {24'h0, `RTCC_TRIM_RESET});
      bus(1'b1, `RTCC_TRIM_ADDR, 8'h25);
      bus(1'b0, `RTCC_TRIM_ADDR, 8'h00);
      cmp({24'h0, o_reg_rdata}, 32'h25);
      bus(1'b1, 8'h05, 8'hFF);
      bus(1'b0, `RTCC_TRIM_ADDR, 8'h00);
      cmp({24'h0, o_reg_rdata}, 32'h25);
      bus(1'b0, 8'h05, 8'h00);
      cmp({24'h0, o_reg_rdata}, 32'h0);
   endtask

   task automatic t_pin;
      bus(1'b1, `RTCC_TRIM_ADDR, 8'h80);
      pin_case(1'b0, 1'b1, 1'b1, 1'b1);
      pin_case(1'b0, 1'b1, 1'b0, 1'b0);
      pin_case(1'b0, 1'b0, 1'b1, 1'b0);
      bus(1'b1, `RTCC_TRIM_ADDR, 8'h00);
      pin_case(1'b0, 1'b0, 1'b0, 1'b1);
      bus(1'b1, `RTCC_TRIM_ADDR, 8'hC0);
      pin_case(1'b1, 1'b1, 1'b1, 1'b0);
      pin_case(1'b0, 1'b1, 1'b1, 1'b1);
   endtask

   // test bit is still set from the pin scenario, so the pin must carry the square wave
   task automatic t_freq;
      @(posedge i_clock);
      #1;
      i_on_backup = 1'b0;
      i_osc_fail_irq_enable = 1'b0;
      i_osc_fail = 1'b0;
      repeat (3) @(posedge i_clock);
      #1;
      count_rises(n, m, q);
      cmp(n, 32'h200);
      cmp(m, 32'h200);
      cmp(q, 32'h0);
   endtask

   // a new trim waits for the first period to close, so seconds stay nominal
   // a whole period is many minutes, beyond this run; trimmed seconds are left to the assertions
   task automatic t_second;
      bus(1'b1, `RTCC_TRIM_ADDR, 8'h3F);
      sec_len(n);
      cmp(n, SEC);
      bus(1'b1, `RTCC_TRIM_ADDR, 8'h1F);
      sec_len(n);
      cmp(n, SEC);
      sec_len(n);
      cmp(n, SEC);
   endtask

   initial begin
      t_reset();
      t_regs();
      t_pin();
      t_freq();
      t_second();
      summarize();
   end

   initial begin
      #1000000;
      err_count++;
      summarize();
   end
endmodule
